// File: verilog/bip_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef BIP_CONSTS_SVH
`define BIP_CONSTS_SVH
`define BIP_A_CTRL 8'h00
`define BIP_A_MASK 8'h04
`define BIP_A_LOW 8'h08
`define BIP_A_EOI 8'h0C
`define BIP_A_POLL 8'h10
`define BIP_A_STAT 8'h14
`define BIP_F_MODE 0
`define BIP_F_SMM 2
`define BIP_F_POLL 3
`define BIP_F_LEVEL 4
`define BIP_F_VBASE 11
`define BIP_CTRL_RST 16'h0000
`define BIP_MASK_RST 8'hFF
`define BIP_LOW_RST 3'h7
`define BIP_RESP_OK 2'h0
`define BIP_RESP_ERR 2'h2
`define BIP_SRC_TMO 24
`define BIP_SRC_MBOX 25
`define BIP_NSRC 26
`define BIP_CLK_NS 4
`define BIP_TMO_NS 10000
`define BIP_TMO_CYC (`BIP_TMO_NS / `BIP_CLK_NS)
`endif

// File: verilog/bip_pkg.sv
// Types shared by the interrupt priority block and its bench
package bip_pkg;
    typedef enum logic [1:0] {
        BIP_NESTED,
        BIP_AUTO,
        BIP_SPEC
    } bip_mode_t;
    typedef logic [4:0] bip_sel_t;
    typedef bip_sel_t [7:0] bip_jsel_t;
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } bip_axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bip_axi_rsp_t;
    typedef struct packed {
        logic adc_done;
        logic copro_err;
        logic line_clk;
        logic power_fail;
        logic periph;
        logic [7:0] user_req;
        logic [2:0] ctr_out;
        logic [5:0] exp_req;
        logic pp_out_empty;
        logic pp_in_full;
    } bip_src_t;
    typedef struct packed {
        logic valid;
        logic [7:0] id;
    } bip_vec_t;
endpackage : bip_pkg

// File: verilog/bip_priority_resolver_unit.sv
// Interrupt priority resolver with AXI4-Lite registers
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bip_consts.svh"
// Operation
// - Nested mode ranks input 0 highest down to input 7 lowest.
// - Auto rotating mode moves each serviced level to lowest priority.
// - Specific rotating mode ranks from the software-named lowest level.
// - Special mask blocks only in-service levels, others stay enabled.
// - Poll mode keeps request line off; poll read returns pending level.
// - Inputs detected on edges or levels as software selects.
// - One combined request line goes to the processor.
// - Acknowledge returns an 8-bit source identifier.
// - Software picks the block of 8 identifiers out of 256.
// - Eight vectored inputs plus the non-maskable level make nine.
// - Jumpers choose inputs from 26 sources with no extra muxing.
// - Parallel port gives input-full and output-empty requests.
// - Each of three expansion connectors gives two request lines.
// - Each of three counters can supply a request.
// - Bus access without acknowledge before timeout raises a request.
// - Conversion done raises a selectable request.
// - External write to shared memory location zero raises a request.
// - Eight user lines, power fail, line clock, coprocessor error.
module bip_priority_resolver_unit #(
    parameter int TMO_CYCLES = `BIP_TMO_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register bus
    input wire bip_pkg::bip_axi_req_t axi_req,
    output bip_pkg::bip_axi_rsp_t axi_rsp,
    // Request sources
    input wire bip_pkg::bip_src_t src,
    input wire logic bus_cycle,
    input wire logic bus_ack,
    input wire logic mbox_wr,
    input wire logic mbox_addr_zero,
    input wire bip_pkg::bip_jsel_t jumper_sel,
    // Processor side
    input wire logic processor_request_line_ack,
    input wire logic nmi_src,
    output logic processor_request_line,
    output bip_pkg::bip_vec_t vec_out,
    output logic local_nonvectored_level
);
    import bip_pkg::*;

    if (TMO_CYCLES < 2 || TMO_CYCLES > 65535) begin : g_chk
        $error("TMO_CYCLES out of range");
    end

    // Pin synchronisers
    localparam int NRAW = 30;
    logic [NRAW-1:0] raw_w, s1_q, s2_q;
    bip_jsel_t j1_q, j2_q, jsel_q;
    assign raw_w = {nmi_src, processor_request_line_ack, mbox_addr_zero, mbox_wr,
                    bus_ack, bus_cycle, src};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw_w;
            s2_q <= s1_q;
        end
    end

    // Jumpers are straps: no reset, caught only while reset is held
    always_ff @(posedge clk) begin
        j1_q <= jumper_sel;
        j2_q <= j1_q;
        if (reset) begin
            jsel_q <= j2_q;
        end
    end

    bip_src_t s_src;
    logic s_cyc, s_ack, s_mwr, s_mz, s_inta, s_nmi;
    assign s_src = s2_q[23:0];
    assign s_cyc = s2_q[24];
    assign s_ack = s2_q[25];
    assign s_mwr = s2_q[26];
    assign s_mz = s2_q[27];
    assign s_inta = s2_q[28];
    assign s_nmi = s2_q[29];

    // Bus timeout one-shot and mailbox strobe
    logic [15:0] tmo_cnt_q;
    logic tmo_act_q, tmo_q, cyc_q, mw_q, mbox_q, tmo_hit;
    assign tmo_hit = tmo_act_q && tmo_cnt_q == 16'(TMO_CYCLES - 1);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tmo_cnt_q <= 16'h0000;
            tmo_act_q <= 1'b0;
            tmo_q <= 1'b0;
            cyc_q <= 1'b0;
            mw_q <= 1'b0;
            mbox_q <= 1'b0;
        end else begin
            cyc_q <= s_cyc;
            mw_q <= s_mwr && s_mz;
            mbox_q <= s_mwr && s_mz && !mw_q;
            tmo_q <= tmo_hit && !s_ack;
            if (s_cyc && !cyc_q) begin
                tmo_act_q <= 1'b1;
                tmo_cnt_q <= 16'h0000;
            end else if (s_ack || tmo_hit) begin
                tmo_act_q <= 1'b0;
            end else if (tmo_act_q) begin
                tmo_cnt_q <= tmo_cnt_q + 16'h0001;
            end
        end
    end

    // Source selection: index 26..31 reads as idle
    logic [31:0] srcx;
    logic [7:0] line_w;
    assign srcx = {6'h00, mbox_q, tmo_q, s_src};
    for (genvar i = 0; i < 8; i++) begin : g_sel
        assign line_w[i] = srcx[jsel_q[i]];
    end

    // Register state
    logic [15:0] ctrl_q;
    logic [7:0] mask_q, irr_q, isr_q, line_q;
    logic [2:0] low_q;
    logic inta_q, smm, pollm, lvlm;
    bip_mode_t mode_w;
    logic [4:0] vbase;
    assign mode_w = (ctrl_q[1:0] == 2'h1) ? BIP_AUTO :
                    (ctrl_q[1:0] == 2'h2) ? BIP_SPEC : BIP_NESTED;
    assign smm = ctrl_q[`BIP_F_SMM];
    assign pollm = ctrl_q[`BIP_F_POLL];
    assign lvlm = ctrl_q[`BIP_F_LEVEL];
    assign vbase = ctrl_q[`BIP_F_VBASE +: 5];
    // First set bit walking up from the level just above the lowest
    function automatic logic [3:0] first_of(input logic [7:0] v,
                                            input logic [2:0] b);
        logic [3:0] r;
        logic [2:0] idx;
        r = 4'h0;
        idx = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            idx = b + 3'h1 + 3'(k);
            if (v[idx]) begin
                r = {1'b1, idx};
            end
        end
        return r;
    endfunction : first_of
    logic [2:0] base_w, p_rank, h_rank, pend;
    logic [7:0] req_eff;
    logic [3:0] p_w, h_w;
    logic grant;
    assign base_w = (mode_w == BIP_NESTED) ? 3'h7 : low_q;
    assign req_eff = irr_q & ~mask_q & (smm ? ~isr_q : 8'hFF);
    assign p_w = first_of(req_eff, base_w);
    assign h_w = first_of(isr_q, base_w);
    assign p_rank = p_w[2:0] - base_w - 3'h1;
    assign h_rank = h_w[2:0] - base_w - 3'h1;
    // Normal nesting holds off equal and lower levels while in service
    assign grant = p_w[3] && (smm || !h_w[3] || p_rank < h_rank);
    assign pend = p_w[2:0];

    // AXI4-Lite handshakes: write waits for address and data together
    logic awr_q, bval_q, arr_q, rval_q, wr_go, rd_go;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, wd;
    logic [7:0] wa, ra;
    assign wr_go = axi_req.awvalid && axi_req.wvalid && !awr_q && !bval_q;
    assign rd_go = axi_req.arvalid && !arr_q && !rval_q;
    assign wa = axi_req.awaddr;
    assign ra = axi_req.araddr;
    assign wd = axi_req.wdata;
    logic w_ctrl, w_mask, w_low, w_eoi, wr_ok, r_poll, rd_ok;
    assign w_ctrl = wr_go && wa == `BIP_A_CTRL;
    assign w_mask = wr_go && wa == `BIP_A_MASK && axi_req.wstrb[0];
    assign w_low = wr_go && wa == `BIP_A_LOW && axi_req.wstrb[0];
    assign w_eoi = wr_go && wa == `BIP_A_EOI;
    assign wr_ok = wa == `BIP_A_CTRL || wa == `BIP_A_MASK ||
                   wa == `BIP_A_LOW || wa == `BIP_A_EOI;
    assign r_poll = rd_go && ra == `BIP_A_POLL;
    // Read decode looks at the read address only
    assign rd_ok = ra == `BIP_A_CTRL || ra == `BIP_A_MASK ||
                   ra == `BIP_A_LOW || ra == `BIP_A_EOI ||
                   ra == `BIP_A_POLL || ra == `BIP_A_STAT;

    logic [31:0] stat_w, poll_w, rd_w;
    assign stat_w = {4'h0, pend, grant, line_w, isr_q, irr_q};
    assign poll_w = {24'h000000, grant, 4'h0, pend};
    assign rd_w = (ra == `BIP_A_CTRL) ? {16'h0000, ctrl_q} :
                  (ra == `BIP_A_MASK) ? {24'h000000, mask_q} :
                  (ra == `BIP_A_LOW) ? {29'h00000000, low_q} :
                  (ra == `BIP_A_POLL) ? poll_w :
                  (ra == `BIP_A_STAT) ? stat_w : 32'h00000000;

    // Acknowledge from either the processor pin or a poll read
    logic inta_ev, ack_ev;
    logic [7:0] set_w, clr_w, rise_w;
    assign inta_ev = s_inta && !inta_q;
    assign ack_ev = inta_ev || r_poll;
    assign set_w = (ack_ev && grant) ? 8'(1) << pend : 8'h00;
    assign clr_w = (w_eoi && h_w[3]) ? 8'(1) << h_w[2:0] : 8'h00;
    assign rise_w = line_w & ~line_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            awr_q <= 1'b0;
            bval_q <= 1'b0;
            bresp_q <= `BIP_RESP_OK;
            arr_q <= 1'b0;
            rval_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `BIP_RESP_OK;
        end else begin
            awr_q <= wr_go;
            arr_q <= rd_go;
            // Response only after the handshake edge, as AXI ordering asks
            if (awr_q) begin
                bval_q <= 1'b1;
            end else if (axi_req.bready) begin
                bval_q <= 1'b0;
            end
            if (wr_go) begin
                bresp_q <= wr_ok ? `BIP_RESP_OK : `BIP_RESP_ERR;
            end
            if (rd_go) begin
                rdata_q <= rd_w;
                rresp_q <= rd_ok ? `BIP_RESP_OK : `BIP_RESP_ERR;
            end
            if (arr_q) begin
                rval_q <= 1'b1;
            end else if (axi_req.rready) begin
                rval_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= `BIP_CTRL_RST;
            mask_q <= `BIP_MASK_RST;
            low_q <= `BIP_LOW_RST;
        end else begin
            if (w_ctrl && axi_req.wstrb[0]) begin
                ctrl_q[7:0] <= wd[7:0];
            end
            if (w_ctrl && axi_req.wstrb[1]) begin
                ctrl_q[15:8] <= wd[15:8] & 8'hF8;
            end
            if (w_mask) begin
                mask_q <= wd[7:0];
            end
            if (w_low && mode_w == BIP_SPEC) begin
                low_q <= wd[2:0];
            end else if (w_eoi && h_w[3] && mode_w == BIP_AUTO) begin
                low_q <= h_w[2:0];
            end
        end
    end

    // Set wins over clear for both request and service flags
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irr_q <= 8'h00;
            isr_q <= 8'h00;
            line_q <= 8'h00;
            inta_q <= 1'b0;
        end else begin
            line_q <= line_w;
            inta_q <= s_inta;
            irr_q <= lvlm ? line_w : (irr_q & ~set_w) | rise_w;
            isr_q <= (isr_q & ~clr_w) | set_w;
        end
    end

    // Processor outputs
    logic processor_request_line_q;
    bip_vec_t vec_q;
    logic nmi_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            processor_request_line_q <= 1'b0;
            vec_q <= '0;
            nmi_q <= 1'b0;
        end else begin
            processor_request_line_q <= grant && !pollm;
            vec_q.valid <= inta_ev;
            if (inta_ev) begin
                vec_q.id <= {vbase, pend};
            end
            nmi_q <= s_nmi;
        end
    end

    assign processor_request_line = processor_request_line_q;
    assign vec_out = vec_q;
    assign local_nonvectored_level = nmi_q;
    assign axi_rsp = '{awready: awr_q, wready: awr_q, bvalid: bval_q,
                       bresp: bresp_q, arready: arr_q, rvalid: rval_q,
                       rdata: rdata_q, rresp: rresp_q};

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_nested;
        mode_w == BIP_NESTED && isr_q == 8'h00 && req_eff[0]
            |-> grant && pend == 3'h0;
    endproperty
    a_nested: assert property (p_nested)
        else $error("nested rank wrong");
    property p_auto;
        mode_w == BIP_AUTO && w_eoi && h_w[3]
            |=> low_q == $past(h_w[2:0]);
    endproperty
    a_auto: assert property (p_auto)
        else $error("rotate after service failed");
    property p_spec;
        w_low && mode_w == BIP_SPEC |=> low_q == $past(wd[2:0]);
    endproperty
    a_spec: assert property (p_spec)
        else $error("lowest level not taken");
    property p_smm;
        smm && grant |-> !isr_q[pend];
    endproperty
    a_smm: assert property (p_smm)
        else $error("in-service level granted");
    property p_poll;
        pollm |=> !processor_request_line;
    endproperty
    a_poll: assert property (p_poll)
        else $error("request line in poll mode");
    property p_edge;
        !lvlm && rise_w != 8'h00
            |=> (irr_q & $past(rise_w)) == $past(rise_w);
    endproperty
    a_edge: assert property (p_edge)
        else $error("edge lost");
    property p_processor_request_line;
        grant && !pollm ##1 grant |-> processor_request_line;
    endproperty
    a_processor_request_line: assert property (p_processor_request_line)
        else $error("request line missing");
    property p_vec;
        inta_ev |=> vec_out.valid && vec_out.id[7:3] == $past(vbase)
            && vec_out.id[2:0] == $past(pend);
    endproperty
    a_vec: assert property (p_vec)
        else $error("identifier wrong");
    property p_tmo;
        tmo_hit && !s_ack |=> tmo_q ##1 !tmo_q;
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("timeout pulse wrong");
    property p_jsel;
        ##1 $stable(jsel_q);
    endproperty
    a_jsel: assert property (p_jsel)
        else $error("jumper selection changed");
endmodule : bip_priority_resolver_unit

// File: tb/bip_host_model.sv
// Processor-side model: acknowledges requests and keeps vectors
`timescale 1ns/1ps
module bip_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bench control
    input wire logic ack_en,
    input wire logic [3:0] ack_gap,
    // Device side
    input wire logic processor_request_line,
    input wire bip_pkg::bip_vec_t vec_out,
    output logic processor_request_line_ack,
    output logic [7:0] last_id,
    output logic [9:0] vec_ptr,
    output logic [7:0] n_vec
);
    import bip_pkg::*;
    logic [3:0] cnt_q;
    // Bench keeps ack_en low in poll mode, the bench polls instead
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            processor_request_line_ack <= 1'b0;
            cnt_q <= 4'h0;
            last_id <= 8'h00;
            vec_ptr <= 10'h000;
            n_vec <= 8'h00;
        end else if (processor_request_line_ack) begin
            cnt_q <= 4'h0;
            if (vec_out.valid) begin
                processor_request_line_ack <= 1'b0;
                last_id <= vec_out.id;
                vec_ptr <= {vec_out.id, 2'b00};
                n_vec <= n_vec + 8'h01;
            end
        end else if (ack_en && processor_request_line) begin
            // A gap after each ack lets the request line settle first
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == ack_gap) begin
                processor_request_line_ack <= 1'b1;
            end
        end else begin
            cnt_q <= 4'h0;
        end
    end
endmodule : bip_host_model

// File: tb/bip_priority_resolver_unit_tb.sv
// Self-checking bench for the interrupt priority resolver
`timescale 1ns/1ps
`include "bip_consts.svh"
module bip_priority_resolver_unit_tb;
    import bip_pkg::*;
    localparam int TMO = 8;
    localparam logic [4:0] VB = 5'h15;
    logic clk = 1'b0;
    logic reset = 1'b1;
    bip_axi_req_t axi_req = '0;
    bip_axi_rsp_t axi_rsp;
    bip_src_t src = '0;
    logic bus_cycle = 1'b0;
    logic bus_ack = 1'b0;
    logic mbox_wr = 1'b0;
    logic mbox_addr_zero = 1'b0;
    bip_jsel_t jumper_sel;
    logic nmi_src = 1'b0;
    logic ack_en = 1'b0;
    logic [3:0] ack_gap = 4'h4;
    logic processor_request_line_ack;
    logic prl;
    logic lnv;
    bip_vec_t vec_out;
    logic [7:0] last_id;
    logic [7:0] n_vec;
    logic [9:0] vptr;
    logic [7:0] nv = 8'h00;
    logic [7:0] e;
    logic [31:0] rdat;
    logic [1:0] resp;
    int err_count = 0;
    int total_checks = 0;
    int g;
    int i;
    always #2 clk = ~clk;
    bip_priority_resolver_unit #(.TMO_CYCLES(TMO)) u_dut (
        .clk(clk), .reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .src(src), .bus_cycle(bus_cycle), .bus_ack(bus_ack),
        .mbox_wr(mbox_wr), .mbox_addr_zero(mbox_addr_zero),
        .jumper_sel(jumper_sel), .processor_request_line_ack(processor_request_line_ack), .nmi_src(nmi_src),
        .processor_request_line(prl), .vec_out(vec_out),
        .local_nonvectored_level(lnv));
    bip_host_model u_host (
        .clk(clk), .reset(reset), .ack_en(ack_en), .ack_gap(ack_gap),
        .processor_request_line(prl), .vec_out(vec_out),
        .processor_request_line_ack(processor_request_line_ack), .last_id(last_id), .vec_ptr(vptr),
        .n_vec(n_vec));
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] y);
        total_checks++;
        if (y !== x) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, x, y);
        end
    endtask : chk
    task automatic tmo;
        chk("wait_done", 32'h1, 32'h0);
        conclude();
    endtask : tmo
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic tdone(input string nm);
        $display("test %s done", nm);
    endtask : tdone
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hF;
        axi_req.bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
            if (axi_rsp.bvalid) break;
        end
        if (n == 50) tmo();
        resp = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
            if (axi_rsp.rvalid) break;
        end
        if (n == 50) tmo();
        rdat = axi_rsp.rdata;
        resp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask : rd
    task automatic eoi;
        wr(`BIP_A_EOI, 32'h0);
    endtask : eoi
    task automatic wait_vec(input string nm, input logic [7:0] x);
        int n;
        nv = nv + 8'h01;
        for (n = 0; n < 100 && n_vec !== nv; n++) @(posedge clk);
        if (n == 100) tmo();
        chk(nm, {24'h0, x}, {24'h0, last_id});
        chk({nm, "_ptr"}, {22'h0, x, 2'b00}, {22'h0, vptr});
    endtask : wait_vec
    task automatic rst;
        cyc(1);
        reset <= 1'b1;
        cyc(8);
        reset <= 1'b0;
        nv = 8'h00;
    endtask : rst
    task automatic fire(input int k);
        if (k < 24) begin
            src <= bip_src_t'(24'h1 << k);
        end else if (k == 24) begin
            bus_cycle <= 1'b1;
        end else begin
            mbox_wr <= 1'b1;
            mbox_addr_zero <= 1'b1;
        end
        cyc(3);
        src <= '0;
        bus_cycle <= 1'b0;
        mbox_wr <= 1'b0;
        mbox_addr_zero <= 1'b0;
        cyc(TMO + 10);
    endtask : fire
    function automatic bip_jsel_t jmap(input int gg);
        bip_jsel_t m;
        for (int k = 0; k < 8; k++)
            m[k] = bip_sel_t'(gg * 8 + k);
        return m;
    endfunction : jmap
    function automatic logic [31:0] ctl(input logic [1:0] m,
        input logic s, input logic p, input logic l);
        return {16'h0, VB, 6'h0, l, p, s, m};
    endfunction : ctl
    initial begin
        jumper_sel = jmap(0);
        // Last group is the identity map, kept for the priority tests
        for (g = 3; g >= 0; g--) begin
            jumper_sel <= jmap(g);
            rst();
            jumper_sel <= '1;
            if (g == 3) begin
                bus_cycle <= 1'b1;
                bus_ack <= 1'b1;
                mbox_wr <= 1'b1;
                cyc(3);
                bus_cycle <= 1'b0;
                mbox_wr <= 1'b0;
                cyc(TMO + 10);
                bus_ack <= 1'b0;
                rd(`BIP_A_STAT);
                chk("stat_quiet", 32'h0, rdat);
            end
            e = 8'h00;
            for (i = 0; i < (g == 3 ? 2 : 8); i++) begin
                fire(g * 8 + i);
                e[i] = 1'b1;
                rd(`BIP_A_STAT);
                chk("stat_req", {24'h0, e}, {24'h0, rdat[7:0]});
            end
        end
        tdone("sources");
        jumper_sel <= jmap(0);
        rst();
        rd(`BIP_A_CTRL);
        chk("ctrl", 32'h0, rdat);
        rd(`BIP_A_MASK);
        chk("mask", 32'hFF, rdat);
        rd(`BIP_A_LOW);
        chk("low", 32'h7, rdat);
        rd(8'h18);
        chk("bad_rresp", 32'h2, {30'h0, resp});
        wr(8'h18, 32'hFFFFFFFF);
        chk("bad_bresp", 32'h2, {30'h0, resp});
        wr(`BIP_A_CTRL, 32'h0000FF17);
        rd(`BIP_A_CTRL);
        chk("ctrl_rb", 32'h0000F817, rdat);
        tdone("registers");
        wr(`BIP_A_MASK, 32'h0);
        wr(`BIP_A_CTRL, ctl(2'd0, 1'b0, 1'b0, 1'b0));
        src <= bip_src_t'(24'h28);
        cyc(8);
        chk("req_line", 32'h1, {31'h0, prl});
        ack_en <= 1'b1;
        wait_vec("vec_n3", {VB, 3'd3});
        eoi();
        wait_vec("vec_n5", {VB, 3'd5});
        eoi();
        src <= '0;
        tdone("nested");
        wr(`BIP_A_MASK, 32'h01);
        src <= bip_src_t'(24'h01);
        cyc(12);
        chk("masked", {24'h0, nv}, {24'h0, n_vec});
        wr(`BIP_A_MASK, 32'h0);
        wait_vec("vec_unmask", {VB, 3'd0});
        eoi();
        src <= '0;
        tdone("mask");
        ack_gap <= 4'hC;
        wr(`BIP_A_CTRL, ctl(2'd1, 1'b0, 1'b0, 1'b0));
        src <= bip_src_t'(24'h01);
        wait_vec("vec_a0", {VB, 3'd0});
        eoi();
        src <= '0;
        cyc(4);
        src <= bip_src_t'(24'h09);
        wait_vec("vec_a3", {VB, 3'd3});
        eoi();
        wait_vec("vec_a0b", {VB, 3'd0});
        eoi();
        src <= '0;
        ack_gap <= 4'h4;
        tdone("auto");
        wr(`BIP_A_CTRL, ctl(2'd2, 1'b0, 1'b0, 1'b0));
        wr(`BIP_A_LOW, 32'h4);
        src <= bip_src_t'(24'h44);
        wait_vec("vec_s6", {VB, 3'd6});
        eoi();
        wait_vec("vec_s2", {VB, 3'd2});
        eoi();
        src <= '0;
        tdone("specific");
        wr(`BIP_A_CTRL, ctl(2'd0, 1'b1, 1'b0, 1'b0));
        src <= bip_src_t'(24'h20);
        wait_vec("vec_m5", {VB, 3'd5});
        src <= bip_src_t'(24'h60);
        wait_vec("vec_m6", {VB, 3'd6});
        eoi();
        eoi();
        src <= '0;
        tdone("special_mask");
        ack_en <= 1'b0;
        wr(`BIP_A_CTRL, ctl(2'd0, 1'b0, 1'b1, 1'b0));
        src <= bip_src_t'(24'h04);
        cyc(8);
        chk("poll_line", 32'h0, {31'h0, prl});
        rd(`BIP_A_POLL);
        chk("poll_word", 32'h82, rdat);
        eoi();
        src <= '0;
        tdone("poll");
        wr(`BIP_A_CTRL, ctl(2'd0, 1'b0, 1'b1, 1'b1));
        src <= bip_src_t'(24'h10);
        cyc(6);
        rd(`BIP_A_STAT);
        chk("lvl_on", 32'h1, {31'h0, rdat[4]});
        src <= '0;
        cyc(6);
        rd(`BIP_A_STAT);
        chk("lvl_off", 32'h0, {31'h0, rdat[4]});
        tdone("level");
        nmi_src <= 1'b1;
        cyc(5);
        chk("nmi_on", 32'h1, {31'h0, lnv});
        nmi_src <= 1'b0;
        cyc(5);
        chk("nmi_off", 32'h0, {31'h0, lnv});
        tdone("nmi");
        conclude();
    end
endmodule : bip_priority_resolver_unit_tb
